// *** verif/dcf_fifo_props.sv ***
`timescale 1ns/1ps
module dcf_fifo_props #(
    parameter int DEPTH = 16384
) (
    input wire logic                             pclk,
    input wire logic                             presetn,
    input wire logic                             reset_in_n,
    input wire logic                             primary_write_enable_n,
    input wire logic                             second_write_enable_or_load,
    input wire logic                             first_read_enable_n,
    input wire logic                             second_read_enable_n,
    input wire logic                             output_enable_n,
    input wire logic [dcf_pkg::DCF_DATA_W-1:0]   read_data_out,
    input wire logic                             read_data_oe_n,
    input wire logic                             empty_flag_n,
    input wire logic                             full_flag_n,
    input wire logic                             almost_empty_flag_n,
    input wire logic                             almost_full_flag_n
);
    import dcf_pkg::*;
    logic dual_reg;
    int   cnt_reg;
    // accepted transfers on each port
    wire  wr_try  = reset_in_n & ~primary_write_enable_n & second_write_enable_or_load;
    wire  wr_take = wr_try & full_flag_n;
    wire  rd_on   = reset_in_n & ~first_read_enable_n & ~second_read_enable_n;
    wire  rd_take = rd_on & empty_flag_n & (dual_reg | second_write_enable_or_load);
    // mode latch and fill level shadow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dual_reg <= 1'b1;
            cnt_reg  <= 0;
        end else if (!reset_in_n) begin
            dual_reg <= second_write_enable_or_load;
            cnt_reg  <= 0;
        end else begin
            cnt_reg <= cnt_reg + int'(wr_take) - int'(rd_take);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    empty_level_a: assert property (empty_flag_n == (cnt_reg != 0))
        else $error("empty flag disagrees with fill level");
    full_level_a: assert property (full_flag_n == (cnt_reg != DEPTH))
        else $error("full flag disagrees with fill level");
    full_block_a: assert property (!full_flag_n && wr_try && !rd_take |=> !full_flag_n)
        else $error("write accepted while full");
    write_wake_a: assert property (wr_take && !empty_flag_n |=> empty_flag_n)
        else $error("stored word did not clear empty");
    empty_hold_a: assert property (!empty_flag_n && rd_on && dual_reg |=> $stable(read_data_out))
        else $error("output changed on read of empty buffer");
    clear_all_a: assert property (!reset_in_n |=> !empty_flag_n && full_flag_n
        && !almost_empty_flag_n && almost_full_flag_n && read_data_out == '0)
        else $error("clear left state behind");
    oe_follow_a: assert property (1'b1 |=> read_data_oe_n == $past(output_enable_n))
        else $error("output enable not followed");
    ae_floor_a: assert property (!empty_flag_n |-> !almost_empty_flag_n)
        else $error("almost empty high while empty");
    af_ceiling_a: assert property (!full_flag_n |-> !almost_full_flag_n)
        else $error("almost full high while full");
endmodule
bind dcf_fifo dcf_fifo_props #(.DEPTH(DEPTH)) i_props (
    .pclk(pclk), .presetn(presetn), .reset_in_n(reset_in_n),
    .primary_write_enable_n(primary_write_enable_n),
    .second_write_enable_or_load(second_write_enable_or_load),
    .first_read_enable_n(first_read_enable_n), .second_read_enable_n(second_read_enable_n),
    .output_enable_n(output_enable_n), .read_data_out(read_data_out),
    .read_data_oe_n(read_data_oe_n), .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n)
);

// *** verif/dcf_partner.sv ***
`timescale 1ns/1ps
module dcf_partner
    import dcf_pkg::*;
(
    input  wire logic                           pclk,
    input  wire logic                           wr_req,
    input  wire logic [dcf_pkg::DCF_DATA_W-1:0] wr_word,
    input  wire logic                           rd_req,
    input  wire logic [dcf_pkg::DCF_DATA_W-1:0] q,
    input  wire logic                           q_oe_n,
    output logic      [dcf_pkg::DCF_DATA_W-1:0] wdata,
    output logic                                wen_n,
    output logic                                first_read_enable_n_n,
    output logic                                second_read_enable_n_n,
    output logic      [dcf_pkg::DCF_DATA_W-1:0] bus
);
    logic [DCF_DATA_W-1:0] idle_reg = 9'h0aa;
    // released lines toggle so stale values never match
    always_ff @(posedge pclk) begin
        idle_reg <= ~idle_reg;
    end
    // producer and consumer, steering enable follows system enable
    assign wen_n  = ~wr_req;
    assign wdata  = wr_req ? wr_word : idle_reg;
    assign first_read_enable_n_n = ~rd_req;
    assign second_read_enable_n_n = ~rd_req;
    // resolved level of the shared output bus
    assign bus = q_oe_n ? idle_reg : q;
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
    import dcf_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [3:0]  pstrb;
    logic        reset_in_n, swe, output_enable_n, wr_req, rd_req;
    logic        wen_n, first_read_enable_n_n, second_read_enable_n_n, oe_n, ef_n, ff_n, ae_n, af_n;
    logic [8:0]  wr_word, wdata, q, bus;
    int          bad_count;
    int          checks;
    dcf_fifo i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .reset_in_n(reset_in_n), .write_data_in(wdata),
        .primary_write_enable_n(wen_n), .second_write_enable_or_load(swe),
        .first_read_enable_n(first_read_enable_n_n), .second_read_enable_n(second_read_enable_n_n),
        .output_enable_n(output_enable_n), .read_data_out(q), .read_data_oe_n(oe_n),
        .empty_flag_n(ef_n), .full_flag_n(ff_n), .almost_empty_flag_n(ae_n),
        .almost_full_flag_n(af_n));
    dcf_partner i_partner (.pclk(pclk), .wr_req(wr_req), .wr_word(wr_word), .rd_req(rd_req),
        .q(q), .q_oe_n(oe_n), .wdata(wdata), .wen_n(wen_n), .first_read_enable_n_n(first_read_enable_n_n),
        .second_read_enable_n_n(second_read_enable_n_n), .bus(bus));
    // clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic finish_test;
        if (bad_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            bad_count++;
            finish_test;
        end
    endtask
    task automatic rst_fifo(input logic dual);
        @(posedge pclk);
        reset_in_n <= 1'b0;
        swe <= dual;
        repeat (2) @(posedge pclk);
        reset_in_n <= 1'b1;
        swe <= 1'b1;
    endtask
    task automatic wr(input int n, input logic [8:0] base);
        @(posedge pclk);
        wr_req <= 1'b1;
        wr_word <= base;
        for (int k = 1; k <= n; k++) begin
            @(posedge pclk);
            if (k < n) wr_word <= base + 9'(k);
            else wr_req <= 1'b0;
        end
        @(negedge pclk);
    endtask
    task automatic rd(input int n, input logic [8:0] base);
        @(posedge pclk);
        rd_req <= 1'b1;
        for (int k = 1; k <= n; k++) begin
            @(posedge pclk);
            if (k == n) rd_req <= 1'b0;
            @(negedge pclk);
            chk(32'(bus), 32'(base + 9'(k - 1)));
        end
    endtask
    task automatic t_basic;
        rst_fifo(1'b1);
        @(negedge pclk);
        chk({ef_n, ff_n, ae_n, af_n}, 4'b0101);
        apb(1'b0, DCF_ADDR_E_OFS, '0);
        chk(rdata[15:0], 16'h0007);
        apb(1'b0, DCF_ADDR_F_OFS, '0);
        chk(rdata[15:0], 16'h0007);
        apb(1'b0, 12'hffc, '0);
        chk(err, 1'b1);
        apb(1'b0, DCF_ADDR_STATUS, '0);
        chk(rdata[4], 1'b1);
    endtask
    task automatic t_stream;
        wr(7, 9'h1f0);
        chk(ae_n, 1'b0);
        wr(1, 9'h1f7);
        chk(ae_n, 1'b1);
        rd(8, 9'h1f0);
        chk(ef_n, 1'b0);
        rd(1, 9'h1f7);
        @(posedge pclk);
        output_enable_n <= 1'b1;
        @(posedge pclk);
        output_enable_n <= 1'b0;
        @(negedge pclk);
        chk(oe_n, 1'b1);
    endtask
    task automatic t_full;
        wr(DCF_DEPTH, 9'h000);
        chk({ff_n, af_n}, 2'b00);
        wr(1, 9'h1aa);
        apb(1'b0, DCF_ADDR_STATUS, '0);
        chk(rdata[31:16], 16'(DCF_DEPTH));
        rd(1, 9'h000);
        chk({ff_n, af_n}, 2'b10);
        rd(7, 9'h001);
        chk(af_n, 1'b1);
        @(posedge pclk);
        wr_req <= 1'b1;
        rd_req <= 1'b1;
        repeat (4) @(posedge pclk);
        wr_req <= 1'b0;
        rd_req <= 1'b0;
        apb(1'b0, DCF_ADDR_STATUS, '0);
        chk(rdata[31:16], 16'(DCF_DEPTH - 8));
        rst_fifo(1'b1);
        @(negedge pclk);
        chk({ef_n, ff_n, ae_n, af_n, bus}, 13'h0a00);
    endtask
    task automatic t_prog;
        rst_fifo(1'b0);
        apb(1'b0, DCF_ADDR_STATUS, '0);
        chk(rdata[4], 1'b0);
        @(posedge pclk);
        swe <= 1'b0;
        wr(1, 9'h002);
        wr(1, 9'h000);
        wr(1, 9'h003);
        wr(1, 9'h000);
        rd(1, 9'h002);
        rd(1, 9'h000);
        rd(1, 9'h003);
        rd(1, 9'h000);
        apb(1'b0, DCF_ADDR_E_OFS, '0);
        chk(rdata[15:0], 16'h0002);
        apb(1'b0, DCF_ADDR_F_OFS, '0);
        chk(rdata[15:0], 16'h0003);
        @(posedge pclk);
        swe <= 1'b1;
        wr(2, 9'h010);
        chk(ae_n, 1'b0);
        wr(1, 9'h012);
        chk(ae_n, 1'b1);
        rd(3, 9'h010);
    endtask
    // watchdog
    initial begin
        #1000000;
        bad_count++;
        finish_test;
    end
    // main sequence
    initial begin
        bad_count = 0;
        checks = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        reset_in_n = 1'b1;
        swe = 1'b1;
        output_enable_n = 1'b0;
        wr_req = 1'b0;
        rd_req = 1'b0;
        wr_word = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_basic;
        t_stream;
        t_full;
        t_prog;
        finish_test;
    end
endmodule

// *** verilog/dcf_fifo.sv ***
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
// What this block does
// [R1] storage of DEPTH words, nine bits each, depth 16384 or 32768
// [R2] dual mode: store input when primary enable low and second enable high
// [R3] one word accepted every clock while both enables stay active
// [R4] no store into memory while full flag is low
// [R5] read advances when both read enables low and buffer not empty
// [R6] writes and reads proceed concurrently and independently
// [R7] works with one shared clock for both ports
// [R8] second enable pin sampled during reset picks dual or programming mode
// [R9] programming mode: primary enable alone gates stores, full flag permitting
// [R10] programming mode with load low: write goes to selected offset register
// [R11] load low with reads enabled: selected offset register goes to output
// [R12] empty flag low when no unread words, clocked
// [R13] full flag low when no free location, clocked
// [R14] almost empty flag low when fill at or below empty offset
// [R15] almost full flag low when free space at or below full offset
// [R16] reset empties buffer and sets flags to empty values
// [R17] the controller must reset once before the first access
// [R18] output driven only while output enable is low; read_data_oe_n is registered and follows the pin one clock later
// [R19] outside logic may use one enable to steer cascaded devices
// [R20] both offsets default to seven words after reset
// [R21] four offset bytes accessed in fixed rotating order
// [R22] almost empty low at count at most offset, high above it
// [R23] almost full returns high once free locations exceed offset
// [R24] reset clears pointers and restarts offset access at first byte
module dcf_fifo #(
    parameter int DEPTH = dcf_pkg::DCF_DEPTH
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic [dcf_pkg::DCF_PADDR_W-1:0] paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       reset_in_n,
    input  wire logic [dcf_pkg::DCF_DATA_W-1:0] write_data_in,
    input  wire logic                       primary_write_enable_n,
    input  wire logic                       second_write_enable_or_load,
    input  wire logic                       first_read_enable_n,
    input  wire logic                       second_read_enable_n,
    input  wire logic                       output_enable_n,
    output logic      [dcf_pkg::DCF_DATA_W-1:0] read_data_out,
    output logic                            read_data_oe_n,
    output logic                            empty_flag_n,
    output logic                            full_flag_n,
    output logic                            almost_empty_flag_n,
    output logic                            almost_full_flag_n
);
    import dcf_pkg::*;

    localparam int ADDR_W = $clog2(DEPTH);
    localparam int CNT_W  = ADDR_W + 1;
    localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
    localparam logic [ADDR_W-1:0] LAST_A = ADDR_W'(DEPTH - 1);

    // mode and pointer state
    dcf_mode_t          mode_reg;
    logic [ADDR_W-1:0]  wptr_reg;
    logic [ADDR_W-1:0]  rptr_reg;
    logic [CNT_W-1:0]   count_reg;
    logic [CNT_W-1:0]   count_next;
    dcf_flags_t         flags_reg;
    dcf_flags_t         flags_next;
    logic [DCF_DATA_W-1:0] dout_reg;
    logic               oe_n_reg;

    // apb state
    logic               pready_reg;
    logic               pslverr_reg;
    logic [31:0]        prdata_reg;

    // decode wires
    logic               clear;
    logic               is_dual;
    logic               offset_load_select_n;
    logic               wr_req;
    logic               wr_fire;
    logic               rd_req;
    logic               rd_fire;
    logic               ofs_wr;
    logic               ofs_rd;
    logic [CNT_W-1:0]   free_next;
    logic [DCF_DATA_W-1:0] mem_rdata;
    logic [7:0]         ofs_rdata;
    logic [15:0]        empty_ofs;
    logic [15:0]        full_ofs;

    logic               apb_access;
    logic               apb_take;
    logic               apb_done;
    logic               hit_status;
    logic               hit_e_ofs;
    logic               hit_f_ofs;
    logic               hit_any;
    logic [31:0]        status_word;
    logic [31:0]        rd_word;
    logic [1:0]         bus_we_e;
    logic [1:0]         bus_we_f;

    // pointer increment with wrap at any depth
    function automatic logic [ADDR_W-1:0] ptr_inc(input logic [ADDR_W-1:0] p);
        ptr_inc = (p == LAST_A) ? '0 : p + 1'b1;
    endfunction

    // reset pin acts as a clocked clear of the buffer
    assign clear   = !reset_in_n;
    assign is_dual = (mode_reg == DCF_MODE_DUAL);

    // load control only exists in programming mode
    assign offset_load_select_n = is_dual ? 1'b1 : second_write_enable_or_load;

    // store request, same pin levels in both modes
    assign wr_req  = !primary_write_enable_n && second_write_enable_or_load; // [R2] [R9]
    assign wr_fire = wr_req && flags_reg.full_n && !clear; // [R4] [R3]

    // offset write while load is low
    assign ofs_wr = !offset_load_select_n && !primary_write_enable_n && !clear; // [R10]

    // read request needs both enables
    assign rd_req  = !first_read_enable_n && !second_read_enable_n;
    assign rd_fire = rd_req && offset_load_select_n && flags_reg.empty_n && !clear; // [R5]

    // offset readback, a write in the same cycle wins
    assign ofs_rd = rd_req && !offset_load_select_n && !ofs_wr && !clear; // [R11]

    // mode captured while the reset pin is held low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= DCF_MODE_DUAL;
        end else if (clear) begin
            mode_reg <= dcf_mode_t'(second_write_enable_or_load); // [R8]
        end
    end

    // storage array
    dcf_mem #(
        .DEPTH  (DEPTH),
        .DATA_W (DCF_DATA_W),
        .ADDR_W (ADDR_W)
    ) u_mem (
        .pclk    (pclk),
        .wr_en   (wr_fire),
        .wr_addr (wptr_reg),
        .wr_data (write_data_in),
        .rd_addr (rptr_reg),
        .rd_data (mem_rdata)
    ); // [R1]

    // flag offset bytes
    dcf_offset_regs u_ofs (
        .pclk      (pclk),
        .presetn   (presetn),
        .clear     (clear),
        .pin_we    (ofs_wr),
        .pin_re    (ofs_rd),
        .pin_wdata (write_data_in[7:0]),
        .bus_we_e  (bus_we_e),
        .bus_we_f  (bus_we_f),
        .bus_wdata (pwdata[15:0]),
        .sel_rdata (ofs_rdata),
        .empty_ofs (empty_ofs),
        .full_ofs  (full_ofs)
    );

    // write pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_reg <= '0;
        end else if (clear) begin
            wptr_reg <= '0; // [R24]
        end else if (wr_fire) begin
            wptr_reg <= ptr_inc(wptr_reg); // [R3]
        end
    end

    // read pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rptr_reg <= '0;
        end else if (clear) begin
            rptr_reg <= '0; // [R24]
        end else if (rd_fire) begin
            rptr_reg <= ptr_inc(rptr_reg);
        end
    end

    // fill level, write and read may coincide
    always_comb begin
        count_next = count_reg;
        unique case ({wr_fire, rd_fire})
            2'b10: count_next = count_reg + 1'b1;
            2'b01: count_next = count_reg - 1'b1;
            2'b11: count_next = count_reg; // [R6] [R7]
            2'b00: count_next = count_reg;
        endcase
        if (clear) begin
            count_next = '0; // [R16]
        end
    end

    assign free_next = DEPTH_C - count_next;

    // flags follow the next fill level
    always_comb begin
        flags_next.empty_n = (count_next != '0); // [R12]
        flags_next.full_n  = (count_next != DEPTH_C); // [R13]
        flags_next.ae_n    = (DCF_OFS_W'(count_next) > empty_ofs); // [R14] [R22]
        flags_next.af_n    = (DCF_OFS_W'(free_next) > full_ofs); // [R15] [R23]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
            flags_reg <= DCF_FLAGS_RST; // [R16]
        end else begin
            count_reg <= count_next;
            flags_reg <= flags_next;
        end
    end

    // output word register, low after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout_reg <= '0;
        end else if (clear) begin
            dout_reg <= '0;
        end else if (rd_fire) begin
            dout_reg <= mem_rdata; // [R5]
        end else if (ofs_rd) begin
            dout_reg <= DCF_DATA_W'(ofs_rdata); // [R11]
        end
    end

    // output enable registered, low means driven
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_n_reg <= 1'b1;
        end else begin
            oe_n_reg <= output_enable_n; // [R18]
        end
    end

    // apb phase decode
    assign apb_access = psel && penable;
    assign apb_take   = apb_access && !pready_reg;
    assign apb_done   = apb_access && pready_reg;

    // address decode
    assign hit_status = (paddr == DCF_ADDR_STATUS);
    assign hit_e_ofs  = (paddr == DCF_ADDR_E_OFS);
    assign hit_f_ofs  = (paddr == DCF_ADDR_F_OFS);
    assign hit_any    = hit_status || hit_e_ofs || hit_f_ofs;

    // offset writes from the bus, byte lanes honoured
    assign bus_we_e = (apb_done && pwrite && hit_e_ofs) ? pstrb[1:0] : 2'b00;
    assign bus_we_f = (apb_done && pwrite && hit_f_ofs) ? pstrb[1:0] : 2'b00;

    // status word shows flags, mode and fill level
    always_comb begin
        status_word = '0;
        status_word[DCF_ST_EMPTY_BIT] = flags_reg.empty_n;
        status_word[DCF_ST_FULL_BIT]  = flags_reg.full_n;
        status_word[DCF_ST_AE_BIT]    = flags_reg.ae_n;
        status_word[DCF_ST_AF_BIT]    = flags_reg.af_n;
        status_word[DCF_ST_MODE_BIT]  = mode_reg;
        status_word[DCF_ST_CNT_LSB +: CNT_W] = count_reg;
    end

    // read mux, unmapped reads as zero
    assign rd_word = hit_status ? status_word :
                     hit_e_ofs  ? {16'h0000, empty_ofs} :
                     hit_f_ofs  ? {16'h0000, full_ofs} :
                     32'h0000_0000;

    // one wait state, answer with pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= apb_take;
            pslverr_reg <= apb_take && !hit_any;
            if (apb_take && !pwrite) begin
                prdata_reg <= rd_word;
            end
        end
    end

    // outputs straight from flip-flops
    assign prdata              = prdata_reg;
    assign pready              = pready_reg;
    assign pslverr             = pslverr_reg;
    assign read_data_out       = dout_reg;
    assign read_data_oe_n      = oe_n_reg;
    assign empty_flag_n        = flags_reg.empty_n;
    assign full_flag_n         = flags_reg.full_n;
    assign almost_empty_flag_n = flags_reg.ae_n;
    assign almost_full_flag_n  = flags_reg.af_n;

endmodule

// *** verilog/dcf_mem.sv ***
`timescale 1ns/1ps
module dcf_mem #(
    parameter int DEPTH  = 16384,
    parameter int DATA_W = 9,
    parameter int ADDR_W = $clog2(DEPTH)
) (
    input  wire logic              pclk,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data
);

    logic [DATA_W-1:0] store_reg [0:DEPTH-1];

    // word storage, no reset on data
    always_ff @(posedge pclk) begin
        if (wr_en) begin
            store_reg[wr_addr] <= wr_data;
        end
    end

    // read port is combinational
    assign rd_data = store_reg[rd_addr];

endmodule

// *** verilog/dcf_offset_regs.sv ***
`timescale 1ns/1ps
module dcf_offset_regs
    import dcf_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clear,
    input  wire logic        pin_we,
    input  wire logic        pin_re,
    input  wire logic [7:0]  pin_wdata,
    input  wire logic [1:0]  bus_we_e,
    input  wire logic [1:0]  bus_we_f,
    input  wire logic [15:0] bus_wdata,
    output logic      [7:0]  sel_rdata,
    output logic      [15:0] empty_ofs,
    output logic      [15:0] full_ofs
);

    dcf_ofs_sel_t sel_reg;
    logic [7:0]   byte_reg [0:DCF_OFS_NUM-1];
    logic [7:0]   byte_next [0:DCF_OFS_NUM-1];
    logic [3:0]   bus_we;

    // bus lanes: index 0/1 empty bytes, 2/3 full bytes
    assign bus_we = {bus_we_f, bus_we_e};

    // pin write lands on the selected byte, bus lane overrides it
    always_comb begin
        for (int i = 0; i < DCF_OFS_NUM; i++) begin
            byte_next[i] = byte_reg[i];
            if (pin_we && sel_idx(sel_reg) == 2'(i)) begin
                byte_next[i] = pin_wdata; // [R10]
            end
            if (bus_we[i]) begin
                byte_next[i] = bus_wdata[8*(i%2) +: 8];
            end
        end
    end

    // byte storage, default seven words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DCF_OFS_NUM; i++) begin
                byte_reg[i] <= (i % 2 == 0) ? DCF_OFS_RST_LSB : DCF_OFS_RST_MSB; // [R20]
            end
        end else if (clear) begin
            for (int i = 0; i < DCF_OFS_NUM; i++) begin
                byte_reg[i] <= (i % 2 == 0) ? DCF_OFS_RST_LSB : DCF_OFS_RST_MSB; // [R20]
            end
        end else begin
            for (int i = 0; i < DCF_OFS_NUM; i++) begin
                byte_reg[i] <= byte_next[i];
            end
        end
    end

    // rotating selection, restarted by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_reg <= DCF_SEL_E_LSB;
        end else if (clear) begin
            sel_reg <= DCF_SEL_E_LSB; // [R24]
        end else if (pin_we || pin_re) begin
            sel_reg <= dcf_ofs_next(sel_reg); // [R21]
        end
    end

    function automatic logic [1:0] sel_idx(input dcf_ofs_sel_t s);
        unique case (s)
            DCF_SEL_E_LSB: sel_idx = 2'h0;
            DCF_SEL_E_MSB: sel_idx = 2'h1;
            DCF_SEL_F_LSB: sel_idx = 2'h2;
            DCF_SEL_F_MSB: sel_idx = 2'h3;
        endcase
    endfunction

    assign sel_rdata = byte_reg[sel_idx(sel_reg)];
    assign empty_ofs = {byte_reg[1], byte_reg[0]};
    assign full_ofs  = {byte_reg[3], byte_reg[2]};

endmodule

// *** verilog/dcf_pkg.sv ***
package dcf_pkg;

    // storage geometry
    localparam int DCF_DEPTH      = 16384;
    localparam int DCF_DATA_W     = 9;
    localparam int DCF_OFS_BYTE_W = 8;
    localparam int DCF_OFS_W      = 16;
    localparam int DCF_OFS_NUM    = 4;

    // offset defaults after reset: seven words
    localparam logic [7:0] DCF_OFS_RST_LSB = 8'h07;
    localparam logic [7:0] DCF_OFS_RST_MSB = 8'h00;

    // apb map
    localparam int          DCF_PADDR_W      = 12;
    localparam logic [11:0] DCF_ADDR_STATUS  = 12'h000;
    localparam logic [11:0] DCF_ADDR_E_OFS   = 12'h004;
    localparam logic [11:0] DCF_ADDR_F_OFS   = 12'h008;

    // status word fields
    localparam int DCF_ST_EMPTY_BIT = 0;
    localparam int DCF_ST_FULL_BIT  = 1;
    localparam int DCF_ST_AE_BIT    = 2;
    localparam int DCF_ST_AF_BIT    = 3;
    localparam int DCF_ST_MODE_BIT  = 4;
    localparam int DCF_ST_CNT_LSB   = 16;

    // offset register access order, gray coded
    typedef enum logic [1:0] {
        DCF_SEL_E_LSB = 2'h0,
        DCF_SEL_E_MSB = 2'h1,
        DCF_SEL_F_LSB = 2'h3,
        DCF_SEL_F_MSB = 2'h2
    } dcf_ofs_sel_t;

    // role of the dual purpose write pin
    typedef enum logic {
        DCF_MODE_PROG = 1'b0,
        DCF_MODE_DUAL = 1'b1
    } dcf_mode_t;

    // the four status flags, all active low
    typedef struct packed {
        logic empty_n;
        logic full_n;
        logic ae_n;
        logic af_n;
    } dcf_flags_t;

    localparam dcf_flags_t DCF_FLAGS_RST = '{empty_n: 1'b0, full_n: 1'b1,
                                             ae_n: 1'b0, af_n: 1'b1};

    // next register in the rotating access order
    function automatic dcf_ofs_sel_t dcf_ofs_next(input dcf_ofs_sel_t s);
        unique case (s)
            DCF_SEL_E_LSB: dcf_ofs_next = DCF_SEL_E_MSB;
            DCF_SEL_E_MSB: dcf_ofs_next = DCF_SEL_F_LSB;
            DCF_SEL_F_LSB: dcf_ofs_next = DCF_SEL_F_MSB;
            DCF_SEL_F_MSB: dcf_ofs_next = DCF_SEL_E_LSB;
        endcase
    endfunction

endpackage
